// ==== rtl/flow_sensor_target.sv ====
// Purpose: Sensor end: I2C target, command decoder, averaging, flags
// Assumes: Flow, temperature and event inputs come from same-clock logic
// Notes: Bus pins pass a two-stage synchroniser; SCL is never stretched
// What this block does
// - Answer as target at address 8
// - Commands arrive as two acknowledged bytes
// - Reads give MSB-first words plus CRC
// - NACK and STOP abort any transfer
// - 0x3608 water, 0x3615 alcohol start measuring
// - First set after 12 ms, latest thereafter
// - NACK read header until data exists
// - Nine bytes: flow, temp, flags, each CRC
// - Master may stop after any word
// - Flags: bit0 air, bit1 high, bit5 smoothing
// - 0x3FF9 stops; 0.5 ms before next command
// - While measuring only stop or reset accepted
// - General call byte 0x06 resets the device
// - No acknowledge for 25 ms after reset
// - Address returns to default after any reset
// - Air and high flags stick until read
// - Mean since readout; smoothing after 100 ms
// - CRC-8 poly 0x31, init 0xFF, no reflection
// - Respond within 25 ms of power-up
`timescale 1ns/1ns
`include "flow_defs.svh"
module flow_sensor_target import flow_pkg::*; #(
   parameter int SAMPLE_CYC = `SAMPLE_CYC,
   parameter int FIRST_CYC = `FIRST_CYC,
   parameter int STOP_CYC = `STOP_CYC,
   parameter int RESET_CYC = `RESET_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   flow_i2c_if.dev bus,
   input wire logic [15:0] i_flow,
   input wire logic [15:0] i_temp,
   input wire logic i_air,
   input wire logic i_high,
   output logic o_measuring,
   output logic o_ipa,
   output logic o_sample,
   output logic o_ready
);
   dev_state_type st_q, st_d;
   logic scl_m, scl_s, sda_m, sda_s;

   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = `CRC_INIT;
      for (int k = 15; k >= 0; k--) begin
         c = (c[7] ^ w[k]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   function automatic logic [7:0] byte_at(input logic [3:0] i, input dev_state_type s);
      logic [15:0] w;
      w = (i < 4'h3) ? s.snap_f : (i < 4'h6) ? s.snap_t : s.snap_g;
      case (i)
         4'h0, 4'h3, 4'h6: byte_at = w[15:8];
         4'h1, 4'h4, 4'h7: byte_at = w[7:0];
         default: byte_at = crc8(w);
      endcase
   endfunction

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else if (i_ce) begin
         scl_m <= bus.scl;
         scl_s <= scl_m;
         sda_m <= bus.sda;
         sda_s <= sda_m;
      end
   end

   always_comb begin
      dev_state_type d;
      logic start, stop, rise, fall, tick, clr_avg, clr_flg, cmd_go, do_rst, rd;
      logic [6:0] adr;
      logic [7:0] txb;
      logic [8:0] r;
      logic signed [31:0] num;
      logic [31:0] qn;
      logic signed [15:0] q;
      d = st_q;
      start = st_q.scl_p && scl_s && st_q.sda_p && !sda_s;
      stop = st_q.scl_p && scl_s && !st_q.sda_p && sda_s;
      rise = scl_s && !st_q.scl_p;
      fall = !scl_s && st_q.scl_p;
      tick = 1'b0;
      clr_avg = 1'b0;
      clr_flg = 1'b0;
      cmd_go = 1'b0;
      do_rst = 1'b0;
      adr = st_q.sh[7:1];
      rd = st_q.sh[0];
      txb = 8'h00;
      r = 9'h000;
      num = 32'sh0;
      qn = 32'h0;
      q = 16'sh0;
      d.scl_p = scl_s;
      d.sda_p = sda_s;
      d.smp_pulse = 1'b0;
      if (st_q.tmr != 21'h0) begin
         d.tmr = st_q.tmr - 21'h1;
      end
      unique case (st_q.mode)
         M_BOOT, M_STOPPING: if (st_q.tmr == 21'h0) d.mode = M_IDLE;
         M_WARM: if (st_q.tmr == 21'h0) begin
            d.mode = M_RUN;
            d.smp = 21'h0;
         end
         M_RUN: if (st_q.smp == 21'h0) begin
            tick = 1'b1;
            d.smp = 21'(SAMPLE_CYC - 1);
         end else begin
            d.smp = st_q.smp - 21'h1;
         end
         M_IDLE: ;
         default: d.mode = M_IDLE;
      endcase
      // Bus engine; a START restarts it from any phase
      if (start) begin
         d.bus = B_ADDR;
         d.bitc = 4'h0;
         d.wcnt = 2'h0;
         d.sda_oe = 1'b0;
      end else if (stop) begin
         d.bus = B_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (st_q.bus)
            B_IDLE: ;
            B_ADDR, B_WR: if (rise && st_q.bitc < 4'h8) begin
               d.sh = {st_q.sh[6:0], sda_s};
               d.bitc = st_q.bitc + 4'h1;
            end else if (fall && st_q.bitc == 4'h8) begin
               d.bus = B_IDLE;
               if (st_q.bus == B_ADDR) begin
                  if (st_q.mode != M_BOOT && ((adr == `ADDR_DEFAULT && (!rd || st_q.have))
                        || (adr == `GC_ADDR && !rd))) begin
                     d.sda_oe = 1'b1;
                     d.bus = B_AACK;
                     d.rw = rd;
                     d.gc = (adr == `GC_ADDR);
                     d.snap_f = st_q.avg;
                     d.snap_t = st_q.temp;
                     d.snap_g = 16'h0;
                     d.snap_g[`FLAG_AIR] = st_q.air;
                     d.snap_g[`FLAG_HIGH] = st_q.high;
                     d.snap_g[`FLAG_EXP] = st_q.expo;
                  end
               end else if (st_q.gc ? st_q.wcnt == 2'h0 : st_q.wcnt < 2'h2) begin
                  d.sda_oe = 1'b1;
                  d.bus = B_WACK;
                  d.wcnt = st_q.wcnt + 2'h1;
                  if (st_q.gc) begin
                     d.gcrst = (st_q.sh == `GC_RESET);
                  end else if (st_q.wcnt == 2'h0) begin
                     d.hi = st_q.sh;
                  end else begin
                     cmd_go = 1'b1;
                  end
               end
            end
            B_AACK, B_WACK: if (fall) begin
               d.bitc = 4'h0;
               d.bus = B_WR;
               d.sda_oe = 1'b0;
               do_rst = st_q.gcrst && st_q.bus == B_WACK;
               if (st_q.bus == B_AACK && st_q.rw) begin
                  txb = byte_at(4'h0, st_q);
                  d.bidx = 4'h0;
                  d.sh = txb;
                  d.sda_oe = !txb[7];
                  d.bus = B_RD;
               end
            end
            B_RD: if (fall) begin
               d.bitc = st_q.bitc + 4'h1;
               d.sh = {st_q.sh[6:0], 1'b0};
               d.sda_oe = !st_q.sh[6];
               if (st_q.bitc == 4'h7) begin
                  d.sda_oe = 1'b0;
                  d.bus = B_RACK;
               end
            end
            B_RACK: if (rise) begin
               d.rack = !sda_s;
               clr_avg = (st_q.bidx == 4'h1);
               clr_flg = (st_q.bidx == 4'h7);
            end else if (fall) begin
               if (!st_q.rack || st_q.bidx == `READ_BYTES - 4'h1) begin
                  d.bus = B_IDLE;
               end else begin
                  txb = byte_at(st_q.bidx + 4'h1, st_q);
                  d.bidx = st_q.bidx + 4'h1;
                  d.bitc = 4'h0;
                  d.sh = txb;
                  d.sda_oe = !txb[7];
                  d.bus = B_RD;
               end
            end
            default: d.bus = B_IDLE;
         endcase
      end
      // Averaging: running mean, then smoothing with factor 1/80
      if (clr_avg) begin
         d.sum = 32'sh0;
         d.n = 8'h00;
         d.expo = 1'b0;
      end
      if (tick) begin
         d.have = 1'b1;
         d.smp_pulse = 1'b1;
         d.temp = i_temp;
         if (d.n < `EXP_SAMPLES) begin
            d.sum = d.sum + {{16{i_flow[15]}}, i_flow};
            d.n = d.n + 8'h01;
            num = d.sum;
            d.ddiv = d.n;
            d.dexp = 1'b0;
         end else begin
            d.expo = 1'b1;
            num = {{16{i_flow[15]}}, i_flow} - {{16{st_q.avg[15]}}, st_q.avg};
            d.ddiv = `EXP_DIV;
            d.dexp = 1'b1;
         end
         d.dneg = num[31];
         d.dnum = num[31] ? 32'(-num) : 32'(num);
         d.drem = 9'h000;
         d.dcnt = 6'h20;
      end else if (st_q.dcnt != 6'h00) begin
         r = {st_q.drem[7:0], st_q.dnum[31]};
         qn = {st_q.dnum[30:0], r >= {1'b0, st_q.ddiv}};
         d.drem = (r >= {1'b0, st_q.ddiv}) ? r - {1'b0, st_q.ddiv} : r;
         d.dnum = qn;
         d.dcnt = st_q.dcnt - 6'h01;
         if (st_q.dcnt == 6'h01) begin
            q = st_q.dneg ? -$signed(qn[15:0]) : $signed(qn[15:0]);
            d.avg = st_q.dexp ? st_q.avg + q : q;
         end
      end
      d.air = (st_q.air && !(clr_flg && st_q.snap_g[`FLAG_AIR])) || (tick && i_air);
      d.high = (st_q.high && !(clr_flg && st_q.snap_g[`FLAG_HIGH])) || (tick && i_high);
      if (cmd_go) begin
         unique case (st_q.mode)
            M_IDLE: if ({st_q.hi, st_q.sh} == `CMD_WATER || {st_q.hi, st_q.sh} == `CMD_IPA) begin
               d.mode = M_WARM;
               d.tmr = 21'(FIRST_CYC);
               d.ipa = ({st_q.hi, st_q.sh} == `CMD_IPA);
               d.have = 1'b0;
               d.sum = 32'sh0;
               d.n = 8'h00;
               d.expo = 1'b0;
            end
            M_WARM, M_RUN: if ({st_q.hi, st_q.sh} == `CMD_STOP) begin
               d.mode = M_STOPPING;
               d.tmr = 21'(STOP_CYC);
               d.have = 1'b0;
            end
            M_BOOT, M_STOPPING: ;
            default: ;
         endcase
      end
      if (do_rst) begin
         d = '0;
         d.tmr = 21'(RESET_CYC);
         d.scl_p = scl_s;
         d.sda_p = sda_s;
      end
      d.meas = (d.mode == M_WARM || d.mode == M_RUN);
      d.ready = (d.mode != M_BOOT);
      st_d = d;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= '0;
         st_q.tmr <= 21'(RESET_CYC);
         st_q.scl_p <= 1'b1;
         st_q.sda_p <= 1'b1;
      end else if (i_ce) begin
         st_q <= st_d;
      end
   end

   assign bus.s_scl_o = 1'b0;
   assign bus.s_scl_oe = 1'b0;
   assign bus.s_sda_o = 1'b0;
   assign bus.s_sda_oe = st_q.sda_oe;
   assign o_measuring = st_q.meas;
   assign o_ipa = st_q.ipa;
   assign o_sample = st_q.smp_pulse;
   assign o_ready = st_q.ready;
endmodule

// ==== shared/flow_defs.svh ====
// Purpose: Shared constants for the flow sensor I2C link
// Assumes: 50 MHz system clock on both ends
// Notes: Cycle counts derive from the times below
`ifndef FLOW_DEFS_SVH
`define FLOW_DEFS_SVH
`define CLK_PERIOD_NS 20
`define CYC_CEIL(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_FLOOR(ns) ((ns) / `CLK_PERIOD_NS)
`define T_SAMPLE_US 500
`define T_FIRST_MS 12
`define T_STOP_US 500
`define T_RESET_MS 25
`define T_EXP_MS 100
`define T_SCL_QTR_NS 2500
`define SAMPLE_CYC `CYC_FLOOR(`T_SAMPLE_US * 1000)
`define FIRST_CYC `CYC_CEIL(`T_FIRST_MS * 1000000)
`define STOP_CYC `CYC_FLOOR(`T_STOP_US * 1000)
`define RESET_CYC `CYC_FLOOR(`T_RESET_MS * 1000000)
`define EXP_SAMPLES 8'((`T_EXP_MS * 1000) / `T_SAMPLE_US)
`define SCL_QTR 8'(`CYC_FLOOR(`T_SCL_QTR_NS))
`define EXP_DIV 8'h50
`define ADDR_DEFAULT 7'h08
`define GC_ADDR 7'h00
`define GC_RESET 8'h06
`define CMD_WATER 16'h3608
`define CMD_IPA 16'h3615
`define CMD_STOP 16'h3FF9
`define CRC_POLY 8'h31
`define CRC_INIT 8'hFF
`define FLAG_AIR 0
`define FLAG_HIGH 1
`define FLAG_EXP 5
`define READ_BYTES 4'h9
`define WB_CTRL 8'h00
`define WB_CMD 8'h04
`define WB_STAT 8'h08
`define WB_DATA0 8'h0C
`define WB_DATA1 8'h10
`define WB_DATA2 8'h14
`define CTRL_GO 8
`endif

// ==== shared/flow_pkg.sv ====
// Purpose: Types shared by both ends of the flow sensor link
// Assumes: Nothing beyond the defs header
// Notes: All state except the pin synchronisers is grouped into packed structs
package flow_pkg;
   typedef enum logic [2:0] {M_BOOT = 3'b000, M_IDLE = 3'b001, M_WARM = 3'b010,
      M_RUN = 3'b011, M_STOPPING = 3'b100} meas_mode_type;
   typedef enum logic [2:0] {B_IDLE = 3'b000, B_ADDR = 3'b001, B_AACK = 3'b010,
      B_WR = 3'b011, B_WACK = 3'b100, B_RD = 3'b101, B_RACK = 3'b110} bus_phase_type;
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10,
      H_STOP = 2'b11} host_phase_type;
   typedef enum logic [1:0] {OP_CMD = 2'b00, OP_READ = 2'b01, OP_RESET = 2'b10} host_op_type;
   typedef struct packed {
      meas_mode_type mode;
      logic ipa, have, meas, ready, smp_pulse;
      logic [20:0] tmr, smp;
      logic signed [31:0] sum;
      logic [7:0] n;
      logic expo, air, high;
      logic signed [15:0] avg;
      logic [15:0] temp;
      logic [5:0] dcnt;
      logic [8:0] drem;
      logic [31:0] dnum;
      logic [7:0] ddiv;
      logic dneg, dexp;
      bus_phase_type bus;
      logic [7:0] sh, hi;
      logic [3:0] bitc, bidx;
      logic [1:0] wcnt;
      logic rw, gc, gcrst, rack, sda_oe, scl_p, sda_p;
      logic [15:0] snap_f, snap_t, snap_g;
   } dev_state_type;
   typedef struct packed {
      host_phase_type ph;
      host_op_type op;
      logic [3:0] nrd, bitn, idx;
      logic [15:0] cmd;
      logic [7:0] qc, sh;
      logic [1:0] q;
      logic [8:0][7:0] rx;
      logic nack, busy, scl_oe, sda_oe, ack;
      logic [31:0] rdat;
   } host_state_type;
endpackage

// ==== shared/flow_i2c_if.sv ====
// Purpose: Open-drain I2C wires between host and sensor ends
// Assumes: Pull-ups are modelled by the wired-AND below
// Notes: A pin is low only while some end enables a low output
`timescale 1ns/1ns
interface flow_i2c_if;
   logic m_scl_o, m_scl_oe, m_sda_o, m_sda_oe;
   logic s_scl_o, s_scl_oe, s_sda_o, s_sda_oe;
   logic scl, sda;
   assign scl = !((m_scl_oe && !m_scl_o) || (s_scl_oe && !s_scl_o));
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
   modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
   modport dev (output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe, input scl, sda);
endinterface

// ==== rtl/flow_i2c_host.sv ====
// Purpose: Host end: I2C master driven from Wishbone registers
// Assumes: Target never stretches SCL
// Notes: SCL period is four quarter ticks
`timescale 1ns/1ns
`include "flow_defs.svh"
module flow_i2c_host import flow_pkg::*; (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   flow_i2c_if.host bus,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack
);
   host_state_type st_q, st_d;
   logic sda_m, sda_s;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else if (i_ce) begin
         sda_m <= bus.sda;
         sda_s <= sda_m;
      end
   end

   always_comb begin
      host_state_type d;
      logic acc, is_tx, last;
      logic [3:0] total;
      logic [7:0] txn;
      d = st_q;
      acc = i_wb_cyc && i_wb_stb && !st_q.ack;
      is_tx = (st_q.op != OP_READ) || (st_q.idx == 4'h0);
      total = (st_q.op == OP_CMD) ? 4'h3 : (st_q.op == OP_RESET) ? 4'h2 : st_q.nrd + 4'h1;
      last = (st_q.idx == total - 4'h1);
      txn = (st_q.op == OP_RESET) ? `GC_RESET : (st_q.idx == 4'h0) ? st_q.cmd[15:8]
         : st_q.cmd[7:0];
      d.ack = acc;
      if (acc) begin
         unique case (i_wb_adr)
            `WB_CTRL: d.rdat = {23'h0, st_q.busy, st_q.nrd, 2'h0, st_q.op};
            `WB_CMD: d.rdat = {16'h0, st_q.cmd};
            `WB_STAT: d.rdat = {30'h0, st_q.nack, st_q.busy};
            `WB_DATA0: d.rdat = st_q.rx[3:0];
            `WB_DATA1: d.rdat = st_q.rx[7:4];
            `WB_DATA2: d.rdat = {24'h0, st_q.rx[8]};
            default: d.rdat = 32'h0;
         endcase
         if (i_wb_we && i_wb_adr == `WB_CMD) begin
            if (i_wb_sel[0]) d.cmd[7:0] = i_wb_dat[7:0];
            if (i_wb_sel[1]) d.cmd[15:8] = i_wb_dat[15:8];
         end
         if (i_wb_we && i_wb_adr == `WB_CTRL && !st_q.busy && i_wb_sel[0]) begin
            d.op = host_op_type'(i_wb_dat[1:0]);
            d.nrd = (i_wb_dat[7:4] > `READ_BYTES) ? `READ_BYTES : i_wb_dat[7:4];
            if (i_wb_sel[1] && i_wb_dat[`CTRL_GO] && i_wb_dat[1:0] != 2'h3) begin
               d.busy = 1'b1;
               d.nack = 1'b0;
               d.ph = H_START;
               d.q = 2'h0;
               d.qc = `SCL_QTR - 8'h01;
            end
         end
      end
      if (st_q.ph != H_IDLE && st_q.qc != 8'h00) begin
         d.qc = st_q.qc - 8'h01;
      end else if (st_q.ph != H_IDLE) begin
         d.qc = `SCL_QTR - 8'h01;
         d.q = st_q.q + 2'h1;
         unique case (st_q.ph)
            H_START: if (st_q.q == 2'h0) begin
               d.sda_oe = 1'b1;
            end else if (st_q.q == 2'h1) begin
               d.scl_oe = 1'b1;
               d.ph = H_BIT;
               d.q = 2'h0;
               d.idx = 4'h0;
               d.bitn = 4'h0;
               d.sh = (st_q.op == OP_RESET) ? {`GC_ADDR, 1'b0}
                  : {`ADDR_DEFAULT, st_q.op == OP_READ};
            end
            H_BIT: unique case (st_q.q)
               2'h0: d.sda_oe = (st_q.bitn < 4'h8) ? (is_tx && !st_q.sh[7]) : (!is_tx && !last);
               2'h1: d.scl_oe = 1'b0;
               2'h2: if (st_q.bitn < 4'h8) begin
                  d.sh = {st_q.sh[6:0], is_tx ? 1'b0 : sda_s};
               end else if (is_tx && sda_s) begin
                  d.nack = 1'b1;
               end
               2'h3: begin
                  d.scl_oe = 1'b1;
                  d.bitn = st_q.bitn + 4'h1;
                  if (st_q.bitn == 4'h8) begin
                     if (!is_tx) d.rx[st_q.idx - 4'h1] = st_q.sh;
                     d.bitn = 4'h0;
                     d.idx = st_q.idx + 4'h1;
                     d.sh = txn;
                     if (d.nack || last) d.ph = H_STOP;
                  end
               end
            endcase
            H_STOP: unique case (st_q.q)
               2'h0: d.sda_oe = 1'b1;
               2'h1: d.scl_oe = 1'b0;
               2'h2: d.sda_oe = 1'b0;
               2'h3: begin
                  d.ph = H_IDLE;
                  d.busy = 1'b0;
               end
            endcase
            H_IDLE: ;
         endcase
      end
      st_d = d;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else if (i_ce) begin
         st_q <= st_d;
      end
   end

   assign bus.m_scl_o = 1'b0;
   assign bus.m_scl_oe = st_q.scl_oe;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe = st_q.sda_oe;
   assign o_wb_dat = st_q.rdat;
   assign o_wb_ack = st_q.ack;
endmodule

// ==== testbench/flow_link_props.sv ====
// Purpose: Assertions on the open-drain link between host and sensor
// Assumes: One clock domain, async active-low reset
// Notes: Watches interface wires plus the sensor ready flag
`timescale 1ns/1ns
module flow_link_props (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic m_scl_o,
   input wire logic m_scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_scl_o,
   input wire logic s_scl_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic scl,
   input wire logic sda,
   input wire logic o_ready
);
   logic [12:0] hold_q;
   logic [12:0] hold_d;
   // Length of one unbroken device drive
   assign hold_d = s_sda_oe ? hold_q + 13'h1 : 13'h0;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_q <= 13'h0;
      end else begin
         hold_q <= hold_d;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_open_drain;
      !m_scl_o && !m_sda_o && !s_scl_o && !s_sda_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("driven high level");
   property p_no_stretch;
      !s_scl_oe;
   endproperty
   a_no_stretch: assert property (p_no_stretch) else $error("clock stretched");
   property p_dev_change;
      $changed(s_sda_oe) |-> !scl;
   endproperty
   a_dev_change: assert property (p_dev_change) else $error("data moved in high");
   property p_blocked;
      !o_ready |-> !s_sda_oe;
   endproperty
   a_blocked: assert property (p_blocked) else $error("answer while blocked");
   property p_hold;
      hold_q <= 13'd4600;
   endproperty
   a_hold: assert property (p_hold) else $error("data held too long");
   property p_scl_low;
      $rose(m_scl_oe) |-> m_scl_oe [*8];
   endproperty
   a_scl_low: assert property (p_scl_low) else $error("clock low too short");
   property p_scl_high;
      $fell(m_scl_oe) |-> !m_scl_oe [*8];
   endproperty
   a_scl_high: assert property (p_scl_high) else $error("clock high too short");
   property p_idle;
      $rose(i_rst_n) |-> scl && sda;
   endproperty
   a_idle: assert property (p_idle) else $error("lines busy after reset");
   property p_start;
      $fell(sda) && scl |-> m_sda_oe && !s_sda_oe;
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_stop;
      $rose(sda) && scl |-> !s_sda_oe;
   endproperty
   a_stop: assert property (p_stop) else $error("stop while driven");
   c_ack: cover property ($rose(s_sda_oe));
   c_start: cover property ($fell(sda) && scl);
   c_block: cover property ($fell(o_ready));
endmodule

// ==== testbench/flow_sensor_i2c_command_interface_tb_top.sv ====
// Purpose: Host and sensor joined, driven over Wishbone
// Assumes: Short counts; bit time 500 clocks
// Notes: Flow and temperature held constant per test
`timescale 1ns/1ns
`include "flow_defs.svh"
module flow_sensor_i2c_command_interface_tb_top;
   localparam int RST_CYC = 6000;
   localparam int SMP_CYC = 64;
   logic i_clk = 1'b0, i_rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, air = 1'b0, wsel;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, o_wb_dat;
   logic [15:0] flow = 16'h0, temp = 16'h0;
   logic ack, measuring, ipa, ready;
   logic high = 1'b0, sample;
   int n_fail = 0, samples_checked = 0;
   int gap = 0;
   always #10 i_clk = ~i_clk;
   flow_i2c_if link();
   flow_sensor_target #(.SAMPLE_CYC(SMP_CYC), .FIRST_CYC(200), .STOP_CYC(50), .RESET_CYC(RST_CYC))
      flow_sensor_target_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .bus(link.dev),
      .i_flow(flow), .i_temp(temp), .i_air(air), .i_high(high), .o_measuring(measuring),
      .o_ipa(ipa), .o_sample(sample), .o_ready(ready));
   flow_i2c_host flow_i2c_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
      .bus(link.host), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat), .o_wb_ack(ack));
   flow_link_props flow_link_props_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .m_scl_o(link.m_scl_o), .m_scl_oe(link.m_scl_oe), .m_sda_o(link.m_sda_o),
      .m_sda_oe(link.m_sda_oe), .s_scl_o(link.s_scl_o), .s_scl_oe(link.s_scl_oe),
      .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda),
      .o_ready(ready));
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
      end
      return c;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do @(posedge i_clk); while (ack !== 1'b1);
      rdat = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // One link transfer, then status left in rdat
   task i2c(input logic [1:0] op, input logic [3:0] cnt, input logic [15:0] cmd);
      wb(1'b1, `WB_CMD, {16'h0, cmd});
      wb(1'b1, `WB_CTRL, {23'h0, 1'b1, cnt, 2'b00, op});
      do wb(1'b0, `WB_STAT, 32'h0); while (rdat[0] !== 1'b0);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (120000) @(posedge i_clk);
      n_fail++;
      stop_test;
   end
   initial begin
      void'($urandom(32'h1091));
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (RST_CYC + 4) @(posedge i_clk);
      chk({31'h0, ready}, 32'h1);
      i2c(2'h1, 4'h1, 16'h0);
      chk({31'h0, rdat[1]}, 32'h1);
      $display("test early read done");
      flow <= 16'($urandom);
      temp <= 16'($urandom);
      wsel = 1'($urandom_range(1));
      air <= 1'b1;
      i2c(2'h0, 4'h0, wsel ? `CMD_IPA : `CMD_WATER);
      chk({31'h0, rdat[1]}, 32'h0);
      chk({30'h0, measuring, ipa}, {30'h0, 1'b1, wsel});
      while (sample !== 1'b1) @(posedge i_clk);
      gap = 0;
      do begin
         @(posedge i_clk);
         gap++;
      end while (sample !== 1'b1);
      chk(gap, SMP_CYC);
      repeat (300) @(posedge i_clk);
      air <= 1'b0;
      high <= 1'b1;
      repeat (400) @(posedge i_clk);
      high <= 1'b0;
      $display("test start done");
      i2c(2'h1, 4'h9, 16'h0);
      chk({31'h0, rdat[1]}, 32'h0);
      wb(1'b0, `WB_DATA0, 32'h0);
      chk(rdat, {temp[15:8], crc8(flow), flow[7:0], flow[15:8]});
      wb(1'b0, `WB_DATA1, 32'h0);
      chk(rdat, {8'h03, 8'h00, crc8(temp), temp[7:0]});
      wb(1'b0, `WB_DATA2, 32'h0);
      chk(rdat, {24'h0, crc8(16'h0003)});
      chk({24'h0, crc8(16'hBEEF)}, 32'h92);
      $display("test read done");
      i2c(2'h2, 4'h0, 16'h0);
      chk({31'h0, rdat[1]}, 32'h0);
      chk({30'h0, measuring, ready}, 32'h0);
      i2c(2'h1, 4'h1, 16'h0);
      chk({31'h0, rdat[1]}, 32'h1);
      for (int k = 0; k < RST_CYC && ready !== 1'b1; k++) @(posedge i_clk);
      i2c(2'h0, 4'h0, `CMD_STOP);
      chk({31'h0, rdat[1]}, 32'h0);
      $display("test soft reset done");
      stop_test;
   end
endmodule
